/* File: verilog/dsc_startup_config.sv */
// serial control port slave with calibration reset and factory coefficient load
`timescale 1ns/10ps
module dsc_startup_config #(
    parameter dsc_pkg::dsc_coef_t FACTORY_COEF = {8'h11, 8'h22, 8'h33, 8'h44}
) (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_n_in,
    // serial control port pins
    input  wire dsc_pkg::dsc_spi_in_s  spi_in,
    output dsc_pkg::dsc_spi_out_s      spi_out,
    // oscillator mode request from the core, same clock
    input  wire logic                  nco_only_in,
    // converter side
    output logic                       four_wire_out,
    output logic                       cal_reset_out,
    output logic                       cal_valid_out,
    output logic                       load_busy_out,
    output logic                       nco_only_out,
    output dsc_pkg::dsc_coef_t         cal_coef_out
);
    import dsc_pkg::*;

    localparam dsc_state_s ST_RST = '{
        cs_n_sy  : 3'b111,
        sclk_sy  : 3'b000,
        sdio_sy  : 3'b000,
        cs_n_f   : 1'b1,
        sclk_f   : 1'b0,
        cnt      : 5'd0,
        sh       : 16'h0000,
        rw       : 1'b0,
        addr     : 15'h0000,
        rd_sh    : 8'h00,
        dout     : 1'b0,
        oe       : 1'b0,
        spcfg    : SERIAL_PORT_CONFIG_RST,
        calrst   : CAL_RESET_CONTROL_RST,
        nvma     : NVM_CONFIG_A_RST,
        nvmb     : NVM_CONFIG_B_RST,
        pass     : 1'b0,
        ld       : LD_IDLE,
        idx      : 2'd0,
        wait_cnt : 4'd0,
        coefs    : '0,
        nco_only : 1'b0
    };

    dsc_state_s s_r;
    dsc_state_s s_nxt;

    // unmapped addresses read as zero
    function automatic logic [7:0] reg_read(input logic [14:0] a, input dsc_state_s s);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_SERIAL_PORT_CONFIG) begin
            v = s.spcfg;
        end else if (a == ADDR_CAL_RESET_CONTROL) begin
            v = s.calrst;
        end else if (a == ADDR_CAL_LOAD_CONTROL) begin
            v[LOAD_GO_BIT]   = (s.ld == LD_RUN);
            v[LOAD_PASS_BIT] = s.pass; // RQ13
        end else if (a == ADDR_NVM_CONFIG_A) begin
            v = s.nvma;
        end else if (a == ADDR_NVM_CONFIG_B) begin
            v = s.nvmb;
        end
        return v;
    endfunction : reg_read

    // level filter: keeps the old level while the last two stages disagree
    function automatic logic agreed(input logic [2:0] sy, input logic old);
        return (sy[1] == sy[2]) ? sy[2] : old;
    endfunction : agreed

    // one step of the coefficient load; a held calibration reset aborts it
    function automatic dsc_state_s load_step(input dsc_state_s s, input logic ok,
                                             input logic held);
        dsc_state_s n;
        n = s;
        if (held) begin
            n.coefs    = '0; // RQ4
            n.pass     = 1'b0;
            n.ld       = LD_IDLE;
            n.idx      = 2'd0;
            n.wait_cnt = 4'd0;
        end else begin
            case (s.ld)
                LD_IDLE: begin
                    n.wait_cnt = 4'd0;
                end
                LD_RUN: begin
                    if (s.wait_cnt == NVM_READ_CYCLES - 4'd1) begin
                        n.wait_cnt = 4'd0;
                        if (ok) begin
                            n.coefs[s.idx] = FACTORY_COEF[s.idx]; // RQ8
                        end
                        if (s.idx == 2'(NUM_COEF - 1)) begin
                            n.ld   = LD_IDLE;
                            // pass only when both nvm set-up values matched
                            n.pass = ok; // RQ13
                        end else begin
                            n.idx = s.idx + 2'd1;
                        end
                    end else begin
                        n.wait_cnt = s.wait_cnt + 4'd1;
                    end
                end
                default: begin
                    n.ld = LD_IDLE;
                end
            endcase
        end
        return n;
    endfunction : load_step

    // register update at the end of a write frame
    function automatic dsc_state_s reg_write(input dsc_state_s s, input logic [7:0] d,
                                             input logic may_start);
        dsc_state_s n;
        n = s;
        if (s.addr == ADDR_SERIAL_PORT_CONFIG) begin
            n.spcfg = d; // RQ3
        end else if (s.addr == ADDR_CAL_RESET_CONTROL) begin
            n.calrst = d; // RQ4
        end else if (s.addr == ADDR_CAL_LOAD_CONTROL) begin
            if (d[LOAD_GO_BIT] && may_start) begin
                n.ld       = LD_RUN; // RQ8
                n.idx      = 2'd0;
                n.wait_cnt = 4'd0;
                n.pass     = 1'b0;
            end
        end else if (s.addr == ADDR_NVM_CONFIG_A) begin
            n.nvma = d;
        end else if (s.addr == ADDR_NVM_CONFIG_B) begin
            n.nvmb = d;
        end
        return n;
    endfunction : reg_write

    logic       in_cal_reset;
    logic       nvm_ok;
    logic       start_ok;
    logic       instr_done;
    logic       wr_strobe;
    logic       rd_shift;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sdi;
    logic [7:0] wdata;

    always_comb begin
        s_nxt        = s_r;
        in_cal_reset = ~s_r.calrst[CALRST_RELEASE_BIT];
        nvm_ok       = (s_r.nvma == NVM_CONFIG_A_REQ) && (s_r.nvmb == NVM_CONFIG_B_REQ);
        sdi          = s_r.sdio_sy[2];
        wdata        = {s_r.sh[6:0], sdi};
        // a running load or a held calibration reset refuses a new start
        start_ok     = !in_cal_reset && (s_r.ld == LD_IDLE);
        instr_done   = (s_r.cnt == SPI_INSTR_BITS - 5'd1);
        wr_strobe    = (s_r.cnt == SPI_FRAME_BITS - 5'd1) && !s_r.rw;
        rd_shift     = s_r.rw && (s_r.cnt >= SPI_INSTR_BITS) && (s_r.cnt < SPI_FRAME_BITS);

        // pin synchronisers; a cs_n or sclk level counts once the last two stages agree, sdio is taken from the last stage
        s_nxt.cs_n_sy = {s_r.cs_n_sy[1:0], spi_in.cs_n};
        s_nxt.sclk_sy = {s_r.sclk_sy[1:0], spi_in.sclk};
        s_nxt.sdio_sy = {s_r.sdio_sy[1:0], spi_in.sdio};
        s_nxt.cs_n_f  = agreed(s_r.cs_n_sy, s_r.cs_n_f);
        s_nxt.sclk_f  = agreed(s_r.sclk_sy, s_r.sclk_f);
        sclk_rise     = ~s_r.sclk_f & s_nxt.sclk_f;
        sclk_fall     = s_r.sclk_f & ~s_nxt.sclk_f;

        s_nxt.nco_only = nco_only_in; // RQ12

        // calibration store and nvm load
        s_nxt = load_step(s_nxt, nvm_ok, in_cal_reset);

        // serial frame: r/w bit, 15 address bits, 8 data bits, msb first
        if (s_nxt.cs_n_f) begin
            s_nxt.cnt = 5'd0;
            s_nxt.oe  = 1'b0;
        end else if (sclk_rise && (s_r.cnt < SPI_FRAME_BITS)) begin
            s_nxt.sh  = {s_r.sh[14:0], sdi};
            s_nxt.cnt = s_r.cnt + 5'd1;
            if (instr_done) begin
                s_nxt.rw    = s_r.sh[14];
                s_nxt.addr  = {s_r.sh[13:0], sdi};
                // captured once so a load ending mid-frame cannot tear the byte
                s_nxt.rd_sh = reg_read({s_r.sh[13:0], sdi}, s_r);
            end
            if (wr_strobe) begin
                s_nxt = reg_write(s_nxt, wdata, start_ok);
            end
        end else if (sclk_fall && rd_shift) begin
            // read data moves on falling sclk, bit 7 first
            s_nxt.dout  = s_r.rd_sh[7];
            s_nxt.rd_sh = {s_r.rd_sh[6:0], 1'b0};
            s_nxt.oe    = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // read data leaves on the shared line in 3-wire mode, on the sdo pin in 4-wire mode
    assign four_wire_out   = s_r.spcfg[SPCFG_SDO_BIT] | s_r.spcfg[SPCFG_SDO_MIRROR_BIT]; // RQ3
    assign spi_out.sdio    = s_r.dout;
    assign spi_out.sdio_oe = s_r.oe & ~four_wire_out;
    assign spi_out.sdo     = s_r.dout;
    assign spi_out.sdo_oe  = s_r.oe & four_wire_out;
    assign cal_reset_out   = ~s_r.calrst[CALRST_RELEASE_BIT]; // RQ5
    assign cal_valid_out   = s_r.pass;
    assign load_busy_out   = (s_r.ld == LD_RUN);
    assign nco_only_out    = s_r.nco_only;
    assign cal_coef_out    = s_r.coefs;

endmodule : dsc_startup_config

/* File: verilog/dsc_pkg.sv */
// constants, types and register map for the dac start-up configuration block
//
// Contract
// RQ1 - host reruns start-up after every power-down, reset
// RQ2 - host writes reserved private registers with given values
// RQ3 - 0x18 at serial_port_config selects 4-wire; default 3-wire
// RQ4 - 0x52 at calibration_reset_control resets calibration registers
// RQ5 - host then writes 0xD2 releasing calibration reset
// RQ6 - host writes 0x02 to register nvm_config_a
// RQ7 - host writes 0x00 to nvm_config_b before load
// RQ8 - 0x01 at calibration_load_control loads factory calibration coefficients
// RQ9 - start-up completes before serial-link configuration
// RQ10 - serdes set up before data links come up
// RQ11 - oscillator configured only after start-up completes
// RQ12 - oscillator alone or mixed, exactly one mode
// RQ13 - bit 1 of calibration_load_control reports successful load
// RQ14 - host issues writes in order, one at a time
package dsc_pkg;

    // register offsets
    localparam logic [14:0] ADDR_SERIAL_PORT_CONFIG   = 15'h0000;
    localparam logic [14:0] ADDR_CAL_RESET_CONTROL    = 15'h00d2;
    localparam logic [14:0] ADDR_CAL_LOAD_CONTROL     = 15'h0604;
    localparam logic [14:0] ADDR_NVM_CONFIG_A         = 15'h0606;
    localparam logic [14:0] ADDR_NVM_CONFIG_B         = 15'h0607;

    // values after reset
    localparam logic [7:0]  SERIAL_PORT_CONFIG_RST    = 8'h00;
    localparam logic [7:0]  CAL_RESET_CONTROL_RST     = 8'hd2;
    localparam logic [7:0]  NVM_CONFIG_A_RST          = 8'h00;
    localparam logic [7:0]  NVM_CONFIG_B_RST          = 8'hff;

    // values the nvm set-up must hold before a load counts as good
    localparam logic [7:0]  NVM_CONFIG_A_REQ          = 8'h02;
    localparam logic [7:0]  NVM_CONFIG_B_REQ          = 8'h00;

    // field positions
    localparam int          SPCFG_SDO_BIT             = 4;
    localparam int          SPCFG_SDO_MIRROR_BIT      = 3;
    localparam int          CALRST_RELEASE_BIT        = 7;
    localparam int          LOAD_GO_BIT               = 0;
    localparam int          LOAD_PASS_BIT             = 1;

    // serial frame: 16 instruction bits, then 8 data bits
    localparam logic [4:0]  SPI_INSTR_BITS            = 5'd16;
    localparam logic [4:0]  SPI_FRAME_BITS            = 5'd24;

    // calibration store
    localparam int          NUM_COEF                  = 4;
    localparam int          COEF_W                    = 8;
    localparam logic [3:0]  NVM_READ_CYCLES           = 4'd3;

    typedef enum logic [0:0] {
        LD_IDLE,
        LD_RUN
    } dsc_load_e;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdio;
    } dsc_spi_in_s;

    typedef struct packed {
        logic sdio;
        logic sdio_oe;
        logic sdo;
        logic sdo_oe;
    } dsc_spi_out_s;

    typedef logic [NUM_COEF-1:0][COEF_W-1:0] dsc_coef_t;

    typedef struct packed {
        logic [2:0]  cs_n_sy;
        logic [2:0]  sclk_sy;
        logic [2:0]  sdio_sy;
        logic        cs_n_f;
        logic        sclk_f;
        logic [4:0]  cnt;
        logic [15:0] sh;
        logic        rw;
        logic [14:0] addr;
        logic [7:0]  rd_sh;
        logic        dout;
        logic        oe;
        logic [7:0]  spcfg;
        logic [7:0]  calrst;
        logic [7:0]  nvma;
        logic [7:0]  nvmb;
        logic        pass;
        dsc_load_e   ld;
        logic [1:0]  idx;
        logic [3:0]  wait_cnt;
        dsc_coef_t   coefs;
        logic        nco_only;
    } dsc_state_s;

endpackage : dsc_pkg

/* File: dv/dsc_startup_config_assertions.sv */
// checker: port-level properties of the start-up configuration block
`timescale 1ns/10ps
module dsc_startup_config_assertions
    import dsc_pkg::*;
#(
    parameter dsc_pkg::dsc_coef_t FACTORY_COEF = '0
) (
    input wire logic                  core_clk_in,
    input wire logic                  rst_n_in,
    input wire dsc_pkg::dsc_spi_in_s  spi_in,
    input wire dsc_pkg::dsc_spi_out_s spi_out,
    input wire logic                  nco_only_in,
    input wire logic                  four_wire_out,
    input wire logic                  cal_reset_out,
    input wire logic                  cal_valid_out,
    input wire logic                  load_busy_out,
    input wire logic                  nco_only_out,
    input wire dsc_pkg::dsc_coef_t    cal_coef_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire oe_any = spi_out.sdio_oe | spi_out.sdo_oe;

    chk_nco_follow:
    assert property (nco_only_out == $past(nco_only_in)) else $error("nco mode lag");
    chk_oe_mode:
    assert property ($rose(oe_any) |-> !spi_in.cs_n && spi_out.sdo_oe == four_wire_out)
        else $error("wrong pin");
    chk_oe_release:
    assert property ($rose(spi_in.cs_n) |-> ##[0:6] !oe_any) else $error("oe stuck");
    chk_busy_len:
    assert property ($rose(load_busy_out) |-> load_busy_out[*8] ##[1:8] !load_busy_out)
        else $error("load length");
    chk_coef_load:
    assert property ($rose(cal_valid_out) |-> cal_coef_out == FACTORY_COEF)
        else $error("coef wrong");
    chk_valid_cause:
    assert property ($rose(cal_valid_out) |-> $past(load_busy_out) || $past(load_busy_out, 2))
        else $error("pass w/o load");
    chk_cal_hold:
    assert property (cal_reset_out[*2] |-> !cal_valid_out && cal_coef_out == '0
        && !load_busy_out) else $error("cal not held");
    chk_no_start:
    assert property ($rose(load_busy_out) |-> !$past(cal_reset_out)) else $error("load in rst");

    cover property ($rose(load_busy_out));
    cover property ($rose(cal_valid_out));
    cover property ($rose(spi_out.sdo_oe));
endmodule : dsc_startup_config_assertions

/* File: dv/dsc_host.sv */
// host model: serial control port master issuing start-up frames
`timescale 1ns/10ps
module dsc_host
    import dsc_pkg::*;
(
    // clock
    input  wire logic                  core_clk_in,
    // serial port
    output dsc_pkg::dsc_spi_in_s       spi_drv_out,
    input  wire dsc_pkg::dsc_spi_out_s spi_rcv_in
);
    logic cs = 1'b1;
    logic ck = 1'b0;
    logic drv = 1'b0;
    wire  sdio_w = spi_rcv_in.sdio_oe ? spi_rcv_in.sdio : drv;
    assign spi_drv_out = '{cs_n: cs, sclk: ck, sdio: sdio_w};

    // one whole frame per call, so frames never overlap
    task automatic xfer(input logic [23:0] f, output logic [7:0] rd);
        rd = 8'h00;
        cs = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // released line shows the inverse of its last level
            drv = (i < 8 && f[23]) ? ~drv : f[i];
            repeat (6) @(negedge core_clk_in);
            if (i < 8)
                rd[i] = spi_rcv_in.sdo_oe ? spi_rcv_in.sdo : sdio_w;
            ck = 1'b1;
            repeat (6) @(negedge core_clk_in);
            ck = 1'b0;
        end
        repeat (6) @(negedge core_clk_in);
        cs = 1'b1;
        repeat (6) @(negedge core_clk_in);
    endtask : xfer
endmodule : dsc_host

/* File: dv/testbench.sv */
// testbench: start-up sequence driven through the serial control port
`timescale 1ns/10ps
module testbench;
    import dsc_pkg::*;
    localparam dsc_coef_t COEF = {8'h5a, 8'hc3, 8'h0f, 8'hf0};
    logic         core_clk_in = 1'b0;
    logic         rst_n_in = 1'b0;
    logic         nco_only_in = 1'b0;
    dsc_spi_in_s  spi_in;
    dsc_spi_out_s spi_out;
    logic         four_wire_out, cal_reset_out, cal_valid_out, load_busy_out, nco_only_out;
    dsc_coef_t    cal_coef_out;
    int           busy_cyc = 0;
    int           b0 = 0;
    logic [7:0]   v;
    int           miscompares = 0;
    int           n_checks = 0;
    int           cyc = 0;

    dsc_startup_config #(.FACTORY_COEF(COEF)) uut (.core_clk_in, .rst_n_in, .spi_in,
        .spi_out, .nco_only_in, .four_wire_out, .cal_reset_out, .cal_valid_out,
        .load_busy_out, .nco_only_out, .cal_coef_out);
    dsc_host host (.core_clk_in, .spi_drv_out(spi_in), .spi_rcv_in(spi_out));

    initial forever #50 core_clk_in = ~core_clk_in;
    // busy is counted mid-cycle, away from the edge that moves it
    always @(negedge core_clk_in) begin
        if (load_busy_out === 1'b1) busy_cyc++;
    end
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer({1'b0, a, d}, v);
    endtask : wr
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        host.xfer({1'b1, a, 8'h00}, v);
        chk("rdata", {24'h0, e}, {24'h0, v});
    endtask : rd_chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        chk("idle", 32'h0, {cal_reset_out, cal_valid_out, four_wire_out});
        rd_chk(ADDR_CAL_RESET_CONTROL, CAL_RESET_CONTROL_RST);
        rd_chk(ADDR_NVM_CONFIG_B, NVM_CONFIG_B_RST);
        // load with nvm not yet set up runs but does not pass
        b0 = busy_cyc;
        wr(ADDR_CAL_LOAD_CONTROL, 8'h01);
        chk("busy", NUM_COEF * NVM_READ_CYCLES, busy_cyc - b0);
        rd_chk(ADDR_CAL_LOAD_CONTROL, 8'h00);
        wr(ADDR_SERIAL_PORT_CONFIG, 8'h18);
        chk("4wire", 32'h1, four_wire_out);
        rd_chk(ADDR_SERIAL_PORT_CONFIG, 8'h18);
        wr(ADDR_CAL_RESET_CONTROL, 8'h52);
        chk("calrst", 32'h1, cal_reset_out);
        b0 = busy_cyc;
        wr(ADDR_CAL_LOAD_CONTROL, 8'h01);
        chk("nobusy", 32'h0, busy_cyc - b0);
        wr(ADDR_CAL_RESET_CONTROL, 8'hd2);
        chk("calrel", 32'h0, cal_reset_out);
        wr(ADDR_NVM_CONFIG_A, 8'h02);
        wr(ADDR_NVM_CONFIG_B, 8'h00);
        rd_chk(ADDR_NVM_CONFIG_B, 8'h00);
        b0 = busy_cyc;
        wr(ADDR_CAL_LOAD_CONTROL, 8'h01);
        chk("busy2", NUM_COEF * NVM_READ_CYCLES, busy_cyc - b0);
        chk("valid", 32'h1, cal_valid_out);
        chk("coef", COEF, cal_coef_out);
        rd_chk(ADDR_CAL_LOAD_CONTROL, 8'h02);
        wr(15'h0123, 8'hff);
        rd_chk(15'h0123, 8'h00);
        nco_only_in = 1'b1;
        repeat (2) @(negedge core_clk_in);
        chk("nco", 32'h1, nco_only_out);
        nco_only_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        chk("mix", 32'h0, nco_only_out);
        wr(ADDR_CAL_RESET_CONTROL, 8'h52);
        chk("clr", 32'h0, {cal_valid_out, cal_coef_out[23:0]});
        rst_n_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        chk("rst", 32'h0, {four_wire_out, cal_reset_out});
        rd_chk(ADDR_NVM_CONFIG_A, NVM_CONFIG_A_RST);
        print_verdict();
    end
endmodule : testbench

bind dsc_startup_config dsc_startup_config_assertions #(.FACTORY_COEF(FACTORY_COEF)) chk_i (
    .core_clk_in, .rst_n_in, .spi_in, .spi_out, .nco_only_in, .four_wire_out,
    .cal_reset_out, .cal_valid_out, .load_busy_out, .nco_only_out, .cal_coef_out);
